//--- core/phy_ctl_pkg.sv
// Constants shared by the role and loopback control block
package phy_ctl_pkg;

    // ***************************************************
    // Management register addresses and fields
    // ***************************************************
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h01;
    localparam logic [4:0] REG_ID1 = 5'h02;
    localparam logic [4:0] REG_ID2 = 5'h03;
    localparam logic [4:0] REG_EXT = 5'h10;

    localparam int CTRL_LOOP_BIT = 14;
    localparam int EXT_MASTER_BIT = 0;
    localparam int EXT_EXTLB_BIT = 1;
    localparam int EXT_INTLB_BIT = 2;
    localparam int EXT_LOCK_BIT = 3;
    localparam int STAT_EXTCAP_BIT = 0;
    localparam int STAT_LINK_BIT = 2;
    localparam int STAT_FD100_BIT = 14;

    // Reset values
    localparam logic RST_MASTER = 1'b0;
    localparam logic RST_LOOP = 1'b0;
    localparam logic RST_MDC = 1'b1;

    // ***************************************************
    // Management frame
    // ***************************************************
    localparam logic [5:0] PRE_LEN = 6'h20;
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hb;
    localparam logic [3:0] TA_FIRST = 4'hc;
    localparam logic [3:0] TA_LAST = 4'hd;
    localparam logic [3:0] DATA_LAST = 4'hf;

    // ***************************************************
    // Timing
    // ***************************************************
    localparam int CLK_NS = 40;
    localparam int TX_LAT_NS = 240;
    localparam int RX_LAT_NS = 780;
    localparam int TX_LAT_CYC = (TX_LAT_NS - 1) / CLK_NS;
    localparam int RX_LAT_CYC = (RX_LAT_NS - 1) / CLK_NS;
    localparam int PATH_CYC = 1;

    typedef enum logic [1:0] {
        S_PRE = 2'h0,
        S_ST = 2'h1,
        S_HDR = 2'h3,
        S_DATA = 2'h2
    } mgmt_e;

endpackage

//--- core/phy_role_loop_ctl.sv
// Role selection, loopback steering and management serial slave
// Functional notes
// - After any reset the device is SLAVE until management sets MASTER.
// - Role comes from forced assignment only; no auto-negotiation exchange.
// - An unmanaged device stays SLAVE.
// - MII transmit to line latency stays below 240 ns.
// - Line to MII receive latency stays below 780 ns.
// - Standard register set is read and written over MDIO, timed by MDC.
// - Extra control and monitor registers are reachable over the same interface.
// - Internal loopback feeds receive path from transmit symbols, not line receiver.
// - External loopback returns decoded line echo through MII receive.
`timescale 1ns/1ps
`default_nettype none

module phy_role_loop_ctl #(
    parameter logic [4:0] PHY_ADDR = 5'h01,
    parameter logic [15:0] ID_HI = 16'h0000, // Arbitrary value
    parameter logic [15:0] ID_LO = 16'h0000, // Arbitrary value
    parameter int NIB_W = 4
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic MDC_I,
    input wire logic MDIO_I,
    output logic MDIO_O,
    output logic MDIO_OE_O,
    input wire logic [NIB_W-1:0] TXD_I,
    input wire logic TX_EN_I,
    output logic [NIB_W-1:0] PMA_TXD_O,
    output logic PMA_TX_EN_O,
    input wire logic [NIB_W-1:0] PMA_RXD_I,
    input wire logic PMA_RX_DV_I,
    input wire logic [NIB_W-1:0] ECHO_RXD_I,
    input wire logic ECHO_RX_DV_I,
    output logic [NIB_W-1:0] RXD_O,
    output logic RX_DV_O,
    input wire logic LINK_ACQ_I,
    input wire logic LINK_UP_I,
    output logic MASTER_O,
    output logic LOOP_INT_O,
    output logic LOOP_EXT_O
);

    // ***************************************************
    // Elaboration checks
    // ***************************************************
    if (NIB_W != 4) begin : g_bad_width
        $error("NIB_W must be 4");
    end
    if (phy_ctl_pkg::PATH_CYC > phy_ctl_pkg::TX_LAT_CYC
            || phy_ctl_pkg::PATH_CYC > phy_ctl_pkg::RX_LAT_CYC) begin : g_bad_lat
        $error("Path latency exceeds limit");
    end

    // ***************************************************
    // State
    // ***************************************************
    typedef struct packed {
        phy_ctl_pkg::mgmt_e st;
        logic [5:0] pre_cnt;
        logic [3:0] cnt;
        logic [15:0] sh;
        logic [4:0] reg_a;
        logic is_rd;
        logic oe;
        logic out;
        logic mdc_q;
        logic master;
        logic lb_int;
        logic lb_ext;
        logic lock;
        logic [NIB_W-1:0] txd;
        logic tx_en;
        logic [NIB_W-1:0] rxd;
        logic rx_dv;
    } state_s;

    state_s r;
    state_s n;
    logic rise;
    logic wr_ev;
    logic [15:0] wr_word;

    function automatic logic [15:0] rd_word(input logic [4:0] a, input state_s s, input logic link);
        logic [15:0] w;
        w = 16'h0000;
        case (a)
            phy_ctl_pkg::REG_CTRL: w[phy_ctl_pkg::CTRL_LOOP_BIT] = s.lb_int;
            phy_ctl_pkg::REG_STAT: begin
                w[phy_ctl_pkg::STAT_EXTCAP_BIT] = 1'b1;
                w[phy_ctl_pkg::STAT_LINK_BIT] = link;
                w[phy_ctl_pkg::STAT_FD100_BIT] = 1'b1;
            end
            phy_ctl_pkg::REG_ID1: w = ID_HI;
            phy_ctl_pkg::REG_ID2: w = ID_LO;
            phy_ctl_pkg::REG_EXT: begin
                w[phy_ctl_pkg::EXT_MASTER_BIT] = s.master;
                w[phy_ctl_pkg::EXT_EXTLB_BIT] = s.lb_ext;
                w[phy_ctl_pkg::EXT_INTLB_BIT] = s.lb_int;
                w[phy_ctl_pkg::EXT_LOCK_BIT] = s.lock;
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    assign rise = MDC_I & ~r.mdc_q;
    assign wr_word = {r.sh[14:0], MDIO_I};
    assign wr_ev = rise && r.st == phy_ctl_pkg::S_DATA && !r.is_rd && r.cnt == phy_ctl_pkg::DATA_LAST;

    always_comb begin
        logic [15:0] nsh;
        logic [15:0] rw;
        nsh = {r.sh[14:0], MDIO_I};
        rw = rd_word(r.reg_a, r, LINK_UP_I);
        n = r;
        n.mdc_q = MDC_I;
        // Single register stage each way keeps both paths far under their limits
        n.txd = TXD_I;
        n.tx_en = TX_EN_I;
        if (r.lb_int) begin
            n.rxd = TXD_I;
            n.rx_dv = TX_EN_I;
        end else if (r.lb_ext) begin
            n.rxd = ECHO_RXD_I;
            n.rx_dv = ECHO_RX_DV_I;
        end else begin
            n.rxd = PMA_RXD_I;
            n.rx_dv = PMA_RX_DV_I;
        end
        if (LINK_ACQ_I) begin
            n.lock = 1'b1;
        end
        if (rise) begin
            case (r.st)
                phy_ctl_pkg::S_PRE: begin
                    if (MDIO_I) begin
                        if (r.pre_cnt != phy_ctl_pkg::PRE_LEN) begin
                            n.pre_cnt = r.pre_cnt + 6'h01;
                        end
                    end else if (r.pre_cnt == phy_ctl_pkg::PRE_LEN) begin
                        n.st = phy_ctl_pkg::S_ST;
                    end else begin
                        n.pre_cnt = 6'h00;
                    end
                end
                phy_ctl_pkg::S_ST: begin
                    n.pre_cnt = 6'h00;
                    n.cnt = 4'h0;
                    n.st = MDIO_I ? phy_ctl_pkg::S_HDR : phy_ctl_pkg::S_PRE;
                end
                phy_ctl_pkg::S_HDR: begin
                    n.sh = nsh;
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == phy_ctl_pkg::HDR_LAST) begin
                        n.is_rd = nsh[11:10] == phy_ctl_pkg::OP_RD;
                        n.reg_a = nsh[4:0];
                        if (nsh[9:5] != PHY_ADDR || (nsh[11:10] != phy_ctl_pkg::OP_RD
                                && nsh[11:10] != phy_ctl_pkg::OP_WR)) begin
                            n.st = phy_ctl_pkg::S_PRE;
                        end
                    end else if (r.cnt == phy_ctl_pkg::TA_FIRST) begin
                        n.oe = r.is_rd;
                        n.out = 1'b0;
                    end else if (r.cnt == phy_ctl_pkg::TA_LAST) begin
                        n.st = phy_ctl_pkg::S_DATA;
                        n.cnt = 4'h0;
                        if (r.is_rd) begin
                            n.sh = rw;
                            n.out = rw[15];
                        end
                    end
                end
                phy_ctl_pkg::S_DATA: begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.is_rd) begin
                        n.sh = {r.sh[14:0], 1'b0};
                        n.out = r.sh[14];
                    end else begin
                        n.sh = nsh;
                    end
                    if (r.cnt == phy_ctl_pkg::DATA_LAST) begin
                        n.oe = 1'b0;
                        n.out = 1'b0;
                        n.st = phy_ctl_pkg::S_PRE;
                    end
                end
                default: n.st = phy_ctl_pkg::S_PRE;
            endcase
        end
        if (wr_ev) begin
            if (r.reg_a == phy_ctl_pkg::REG_CTRL) begin
                n.lb_int = wr_word[phy_ctl_pkg::CTRL_LOOP_BIT];
                if (wr_word[phy_ctl_pkg::CTRL_LOOP_BIT]) begin
                    n.lb_ext = 1'b0;
                end
            end else if (r.reg_a == phy_ctl_pkg::REG_EXT) begin
                if (!r.lock) begin
                    n.master = wr_word[phy_ctl_pkg::EXT_MASTER_BIT];
                end
                n.lb_int = wr_word[phy_ctl_pkg::EXT_INTLB_BIT];
                n.lb_ext = wr_word[phy_ctl_pkg::EXT_EXTLB_BIT] && !wr_word[phy_ctl_pkg::EXT_INTLB_BIT];
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            r <= '0;
            r.st <= phy_ctl_pkg::S_PRE;
            // An idle-high MDC must not look like a rise once reset ends
            r.mdc_q <= phy_ctl_pkg::RST_MDC;
            r.master <= phy_ctl_pkg::RST_MASTER;
            r.lb_int <= phy_ctl_pkg::RST_LOOP;
            r.lb_ext <= phy_ctl_pkg::RST_LOOP;
        end else begin
            r <= n;
        end
    end

    assign MDIO_O = r.out;
    assign MDIO_OE_O = r.oe;
    assign PMA_TXD_O = r.txd;
    assign PMA_TX_EN_O = r.tx_en;
    assign RXD_O = r.rxd;
    assign RX_DV_O = r.rx_dv;
    assign MASTER_O = r.master;
    assign LOOP_INT_O = r.lb_int;
    assign LOOP_EXT_O = r.lb_ext;

    // ***************************************************
    // Assertions
    // ***************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence ta_read_s;
        rise && r.st == phy_ctl_pkg::S_HDR && r.cnt == phy_ctl_pkg::TA_FIRST && r.is_rd;
    endsequence
    sequence ta_drive_s;
        MDIO_OE_O && !MDIO_O;
    endsequence

    a_reset_slave: assert property ($fell(SYS_RST_I) |-> !MASTER_O) else $error("Not slave after reset");
    a_role_forced: assert property ($changed(MASTER_O) |->
        $past(wr_ev) && $past(r.reg_a) == phy_ctl_pkg::REG_EXT) else $error("Role changed without write");
    a_role_locked: assert property (r.lock |=> $stable(MASTER_O)) else $error("Role changed after lock");
    a_unmanaged_slave: assert property (!MASTER_O && !wr_ev |=> !MASTER_O) else $error("Left slave unmanaged");
    a_tx_latency: assert property (1'b1 |=> PMA_TXD_O == $past(TXD_I) && PMA_TX_EN_O == $past(TX_EN_I))
        else $error("Transmit path latency wrong");
    a_rx_latency: assert property (!LOOP_INT_O && !LOOP_EXT_O ##1 !$past(LOOP_INT_O)
        |-> RXD_O == $past(PMA_RXD_I) && RX_DV_O == $past(PMA_RX_DV_I)) else $error("Receive path latency wrong");
    a_mdio_turn: assert property (ta_read_s |=> ta_drive_s ##1 MDIO_OE_O)
        else $error("Turnaround not driven");
    a_ext_write: assert property (wr_ev && r.reg_a == phy_ctl_pkg::REG_EXT && !r.lock
        |=> MASTER_O == $past(wr_word[phy_ctl_pkg::EXT_MASTER_BIT])) else $error("Extra register write lost");
    a_int_loop: assert property (LOOP_INT_O |=> RX_DV_O == $past(TX_EN_I) && RXD_O == $past(TXD_I))
        else $error("Internal loopback wrong");
    a_ext_loop: assert property (LOOP_EXT_O |=> RXD_O == $past(ECHO_RXD_I) && RX_DV_O == $past(ECHO_RX_DV_I))
        else $error("External loopback wrong");
    a_one_loop: assert property (!(LOOP_INT_O && LOOP_EXT_O)) else $error("Two loopbacks active");

endmodule

`default_nettype wire

//--- testbench/mgmt_station.sv
// Station manager model that drives management frames and collects read data
`timescale 1ns/1ps
`default_nettype none
module mgmt_station (
    input wire logic clk_i,
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // Clock low and high for three system cycles each; line released during read turnaround
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffffffff, 2'h1, op, pa, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clk_i);
            mdc_o <= 1'b0;
            mdio_o <= f[i];
            mdio_oe_o <= !(op == phy_ctl_pkg::OP_RD && i < 18);
            repeat (3) @(posedge clk_i);
            if (i < 16) begin
                rd = {rd[14:0], mdio_i};
            end
            mdc_o <= 1'b1;
            repeat (2) @(posedge clk_i);
        end
        @(posedge clk_i);
        mdio_oe_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/phy_role_loop_ctl_bench.sv
// Self-checking bench for the role and loopback control block
`timescale 1ns/1ps
`default_nettype none
module phy_role_loop_ctl_bench;
    localparam logic [4:0] PA = 5'h01;
    // Arbitrary identifier values, chosen only to be told apart
    localparam logic [15:0] ID_HI_V = 16'h1a2b;
    localparam logic [15:0] ID_LO_V = 16'h3c4d;
    logic clk, rst, mdc, st_mdio, st_oe, mdio_o, mdio_oe, mdio_w;
    logic tx_en, pma_dv, echo_dv, link_acq, link_up;
    logic pma_tx_en, rx_dv, master, loop_int, loop_ext;
    logic [3:0] txd, pma_rxd, echo_rxd, pma_txd, rxd;
    logic [15:0] rd;
    int error_cnt = 0;
    int cmp_count = 0;

    // Management line has a pull-up
    assign mdio_w = mdio_oe ? mdio_o : (st_oe ? st_mdio : 1'b1);

    phy_role_loop_ctl #(.PHY_ADDR(PA), .ID_HI(ID_HI_V), .ID_LO(ID_LO_V)) phy_role_loop_ctl_inst (
        .CLK_I(clk), .SYS_RST_I(rst), .MDC_I(mdc), .MDIO_I(mdio_w), .MDIO_O(mdio_o),
        .MDIO_OE_O(mdio_oe), .TXD_I(txd), .TX_EN_I(tx_en), .PMA_TXD_O(pma_txd),
        .PMA_TX_EN_O(pma_tx_en), .PMA_RXD_I(pma_rxd), .PMA_RX_DV_I(pma_dv),
        .ECHO_RXD_I(echo_rxd), .ECHO_RX_DV_I(echo_dv), .RXD_O(rxd), .RX_DV_O(rx_dv),
        .LINK_ACQ_I(link_acq), .LINK_UP_I(link_up), .MASTER_O(master),
        .LOOP_INT_O(loop_int), .LOOP_EXT_O(loop_ext));
    mgmt_station mgmt_station_inst (.clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(st_mdio),
        .mdio_oe_o(st_oe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wreg(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
        mgmt_station_inst.xfer(phy_ctl_pkg::OP_WR, pa, ra, wd, rd);
    endtask

    task automatic rreg(input logic [4:0] ra);
        mgmt_station_inst.xfer(phy_ctl_pkg::OP_RD, PA, ra, 16'h0000, rd);
    endtask

    // Distinct nibbles on every source; mode 0 line, 1 internal, 2 external
    task automatic nib(input int mode);
        logic [4:0] ex;
        for (int v = 0; v < 16; v++) begin
            @(posedge clk);
            txd <= v[3:0];
            tx_en <= v[0];
            pma_rxd <= ~v[3:0];
            pma_dv <= ~v[0];
            echo_rxd <= v[3:0] ^ 4'h5;
            echo_dv <= v[1];
            ex = (mode == 1) ? {v[0], v[3:0]} : (mode == 2) ? {v[1], v[3:0] ^ 4'h5} : {~v[0], ~v[3:0]};
            @(posedge clk);
            #1;
            chk({11'h0, pma_tx_en, pma_txd}, {11'h0, v[0], v[3:0]}, "tx path");
            chk({11'h0, rx_dv, rxd}, {11'h0, ex}, "rx path");
        end
    endtask

    task automatic t_reset;
        chk({13'h0, master, loop_int, loop_ext}, 16'h0000, "reset role");
        rreg(phy_ctl_pkg::REG_EXT);
        chk(rd, 16'h0000, "ext reg");
        rreg(phy_ctl_pkg::REG_STAT);
        chk(rd & 16'h400d, 16'h4001, "status");
        link_up <= 1'b1;
        rreg(phy_ctl_pkg::REG_STAT);
        chk(rd & 16'h400d, 16'h4005, "status link");
        rreg(phy_ctl_pkg::REG_ID1);
        chk(rd, ID_HI_V, "id high");
        rreg(phy_ctl_pkg::REG_ID2);
        chk(rd, ID_LO_V, "id low");
        wreg(PA, 5'h05, 16'hffff);
        chk({13'h0, master, loop_int, loop_ext}, 16'h0000, "unmapped write");
        rreg(5'h05);
        chk(rd, 16'h0000, "unmapped");
        nib(0);
        $display("t_reset done");
    endtask

    task automatic t_role;
        wreg(PA + 5'h01, phy_ctl_pkg::REG_EXT, 16'h0001);
        chk({15'h0, master}, 16'h0000, "foreign address");
        mgmt_station_inst.xfer(2'h3, PA, phy_ctl_pkg::REG_EXT, 16'h0001, rd);
        chk({15'h0, master}, 16'h0000, "bad opcode");
        wreg(PA, phy_ctl_pkg::REG_EXT, 16'h0001);
        chk({15'h0, master}, 16'h0001, "set master");
        link_acq <= 1'b1;
        wreg(PA, phy_ctl_pkg::REG_EXT, 16'h0000);
        chk({15'h0, master}, 16'h0001, "locked role");
        rreg(phy_ctl_pkg::REG_EXT);
        chk(rd, 16'h0009, "ext locked");
        @(posedge clk);
        link_acq <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({15'h0, master}, 16'h0000, "slave again");
        rreg(phy_ctl_pkg::REG_EXT);
        chk(rd, 16'h0000, "lock cleared");
        $display("t_role done");
    endtask

    task automatic t_loop;
        wreg(PA, phy_ctl_pkg::REG_CTRL, 16'h4000);
        chk({14'h0, loop_int, loop_ext}, 16'h0002, "int loop");
        rreg(phy_ctl_pkg::REG_CTRL);
        chk(rd, 16'h4000, "ctrl readback");
        nib(1);
        wreg(PA, phy_ctl_pkg::REG_EXT, 16'h0002);
        chk({14'h0, loop_int, loop_ext}, 16'h0001, "ext loop");
        nib(2);
        wreg(PA, phy_ctl_pkg::REG_CTRL, 16'h4000);
        chk({14'h0, loop_int, loop_ext}, 16'h0002, "ctrl clears ext");
        wreg(PA, phy_ctl_pkg::REG_EXT, 16'h0006);
        chk({14'h0, loop_int, loop_ext}, 16'h0002, "both set");
        rreg(phy_ctl_pkg::REG_EXT);
        chk(rd, 16'h0004, "ext readback");
        wreg(PA, phy_ctl_pkg::REG_EXT, 16'h0000);
        chk({13'h0, master, loop_int, loop_ext}, 16'h0000, "loops off");
        nib(0);
        $display("t_loop done");
    endtask

    task automatic test_done;
        $display("Counts: %0d compares, %0d errors", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {rst, txd, tx_en, pma_rxd, pma_dv, echo_rxd, echo_dv, link_acq, link_up} <= 18'h20000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_role;
        t_loop;
        test_done;
    end

    // Roughly twenty frames of 384 cycles each; allow several times that
    initial begin
        #2000000;
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        test_done;
    end
endmodule
`default_nettype wire
